// [common/dnpc_pkg.sv]
package dnpc_pkg;

    // register byte addresses on the AXI4-Lite port, and register reset values
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SWEEP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PHASE = 8'h0c;
    localparam logic [7:0] ADDR_PROF_BASE = 8'h10;
    localparam logic [7:0] ADDR_PROF_LAST = 8'h2c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SWEEP_RESET = 32'h0000_0000;

    // control function register field positions
    localparam int CTRL_REF_HALF = 0;
    localparam int CTRL_SWEEP = 1;
    localparam int CTRL_SLEEP = 3;
    localparam int CTRL_REF_DIV_LO = 4;
    localparam int CTRL_FB_DIV_LO = 6;
    localparam int CTRL_CP_POL = 10;
    localparam int CTRL_FINAL_LO = 11;
    localparam int CTRL_CP_OFFSET = 13;
    localparam int CTRL_WIDE_LO = 14;
    localparam int CTRL_FDET_LO = 17;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // pfd input divider ratio codes
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;

    // sync clock is the reference clock divided by this
    localparam int SYNC_DIV = 8;
    localparam int SYNC_CNT_W = $clog2(SYNC_DIV);

    // pump current in multiples of the baseline current
    localparam int CP_BASE_UA = 500;
    localparam int CP_OFFSET_UA = 2000;
    localparam logic [5:0] CP_OFFSET_UNITS = 6'(CP_OFFSET_UA / CP_BASE_UA);
    localparam logic [5:0] CP_FDET_STEP = 6'h14;
    localparam logic [5:0] CP_WIDE_STEP = 6'h02;
    localparam logic [5:0] CP_FINAL_BASE = 6'h01;

    typedef enum logic [1:0] {CP_FDET, CP_WIDE, CP_FINAL} dnpc_cpmode_t;

    typedef struct packed {
        logic [1:0] fdetSel;
        logic [2:0] wideSel;
        logic cpOffset;
        logic [1:0] finalSel;
        logic cpPolNeg;
        logic [1:0] fbDiv;
        logic [1:0] refDiv;
        logic sleep;
        logic sweep;
        logic refHalf;
    } dnpc_cfg_t;

    typedef struct packed {
        logic [31:0] freq_tuning_word;
        logic [13:0] poff;
    } dnpc_prof_t;

    function automatic dnpc_cfg_t dnpc_decode(input logic [31:0] w);
        dnpc_cfg_t c;
        c.refHalf = w[CTRL_REF_HALF];
        c.sweep = w[CTRL_SWEEP];
        c.sleep = w[CTRL_SLEEP];
        c.refDiv = w[CTRL_REF_DIV_LO +: 2];
        c.fbDiv = w[CTRL_FB_DIV_LO +: 2];
        c.cpPolNeg = w[CTRL_CP_POL];
        c.finalSel = w[CTRL_FINAL_LO +: 2];
        c.cpOffset = w[CTRL_CP_OFFSET];
        c.wideSel = w[CTRL_WIDE_LO +: 3];
        c.fdetSel = w[CTRL_FDET_LO +: 2];
        return c;
    endfunction

endpackage

// [design/dnpc_pfd_div.sv]
`timescale 1ns/1ns
// divides the rising edges of one pfd input by 1, 2 or 4
module dnpc_pfd_div import dnpc_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic sigIn,
    input wire logic [1:0] ratio,
    output logic edgeOut
);
    logic prev_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic edge_q;
    logic edge_d;
    wire logic rise = sigIn & ~prev_q;
    // reserved ratio code behaves as divide by one
    wire logic [1:0] lastCnt = (ratio == DIV_BY4) ? 2'h3 :
                               (ratio == DIV_BY2) ? 2'h1 : 2'h0;

    always_comb begin
        cnt_d = cnt_q;
        edge_d = 1'b0;
        if (rise) begin
            if (cnt_q >= lastCnt) begin
                cnt_d = 2'h0;
                edge_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
            cnt_q <= 2'h0;
            edge_q <= 1'b0;
        end else if (clkEn) begin
            prev_q <= sigIn;
            cnt_q <= cnt_d;
            edge_q <= edge_d;
        end
    end

    assign edgeOut = edge_q;
endmodule

// [design/dnpc_cp_ctrl.sv]
`timescale 1ns/1ns
// phase frequency detector, pump polarity and fast lock current control
module dnpc_cp_ctrl import dnpc_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic restart,
    input wire logic refEdge,
    input wire logic fbEdge,
    input wire logic freqLock,
    input wire logic phaseLock,
    input wire dnpc_cfg_t cfg,
    output logic pumpUp,
    output logic pumpDown,
    output dnpc_cpmode_t pumpMode,
    output logic [5:0] pumpScale,
    output logic fastLockActive
);
    dnpc_cpmode_t mode_q;
    dnpc_cpmode_t mode_d;
    logic ref_q;
    logic fb_q;
    logic up_q;
    logic dn_q;
    logic [5:0] scale_q;
    logic fl_q;

    // both flags set means the edges met; the pair clears
    wire logic refSet = ref_q | refEdge;
    wire logic fbSet = fb_q | fbEdge;
    wire logic both = refSet & fbSet;
    wire logic refLead = refSet & ~both;
    wire logic fbLead = fbSet & ~both;
    // feedback leading lowers the control node unless inverted
    wire logic upNext = cfg.cpPolNeg ? fbLead : refLead;
    wire logic dnNext = cfg.cpPolNeg ? refLead : fbLead;

    wire logic [5:0] fdetScale = 6'(cfg.fdetSel) * CP_FDET_STEP;
    wire logic [5:0] wideScale = 6'(cfg.wideSel) * CP_WIDE_STEP;
    wire logic [5:0] finalScale = 6'(cfg.finalSel) + CP_FINAL_BASE +
        (cfg.cpOffset ? CP_OFFSET_UNITS : 6'h00);
    wire logic [5:0] scaleNext = (mode_d == CP_FDET) ? fdetScale :
                                 (mode_d == CP_WIDE) ? wideScale : finalScale;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            CP_FDET: begin
                if (freqLock) begin
                    mode_d = (cfg.wideSel == 3'h0) ? CP_FINAL : CP_WIDE;
                end
            end
            CP_WIDE: begin
                if (phaseLock) begin
                    mode_d = CP_FINAL;
                end
            end
            default: mode_d = mode_q;
        endcase
        if (restart) begin
            mode_d = CP_FDET;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= CP_FDET;
            ref_q <= 1'b0;
            fb_q <= 1'b0;
            up_q <= 1'b0;
            dn_q <= 1'b0;
            scale_q <= 6'h00;
            fl_q <= 1'b0;
        end else if (clkEn) begin
            mode_q <= mode_d;
            ref_q <= refLead & ~restart;
            fb_q <= fbLead & ~restart;
            up_q <= upNext & ~restart;
            dn_q <= dnNext & ~restart;
            scale_q <= restart ? 6'h00 : scaleNext;
            fl_q <= (mode_d == CP_FDET) & ~restart;
        end
    end

    assign pumpUp = up_q;
    assign pumpDown = dn_q;
    assign pumpMode = mode_q;
    assign pumpScale = scale_q;
    assign fastLockActive = fl_q;
endmodule

// [design/dnpc_top.sv]
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - 32-bit accumulator adds tuning word each tick
// - 14-bit phase offset added before sine
// - four profiles chosen by two select pins
// - each profile holds tuning word and offset
// - optional halving of reference for system clock
// - mode is single tone or sweep
// - full sleep stops most logic
// - each pfd input divided by 1, 2, 4
// - polarity sets pump direction versus lead/lag
// - control bit 10 selects pump polarity
// - final mode scale one to four
// - control bit 13 adds 2 mA offset
// - wide mode scale even zero to fourteen
// - frequency detect scale 0, 20, 40, 60
// - zero wide scale skips to final mode
// - update strobe rise copies buffers to active
// - sync clock out is reference over eight
module dnpc_top import dnpc_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [1:0] profileSelect,
    input wire logic updateStrobe,
    input wire logic pfdReferenceInput,
    input wire logic pfdFeedbackInput,
    input wire logic freqLockDet,
    input wire logic phaseLockDet,
    output logic syncClockOut,
    output logic systemClockTick,
    output logic [13:0] phaseOut,
    output logic pumpUp,
    output logic pumpDown,
    output dnpc_cpmode_t pumpMode,
    output logic [5:0] pumpScale,
    output logic fastLockActive
);
    // buffered (software side) and active copies
    logic [31:0] ctrlBuf_q;
    logic [31:0] sweepBuf_q;
    dnpc_prof_t profBuf_q [4];
    logic [31:0] ctrlAct_q;
    logic [31:0] sweepAct_q;
    dnpc_prof_t profAct_q [4];

    logic awReady_q;
    logic wReady_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic arReady_q;
    logic rValid_q;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;

    logic updPrev_q;
    logic [SYNC_CNT_W-1:0] syncCnt_q;
    logic syncClk_q;
    logic halfPhase_q;
    logic sysTick_q;
    logic [31:0] acc_q;
    logic [31:0] sweepFtw_q;
    logic [13:0] phase_q;

    wire dnpc_cfg_t cfg = dnpc_decode(ctrlAct_q);
    wire dnpc_prof_t selProf = profAct_q[profileSelect];
    wire logic updRise = updateStrobe & ~updPrev_q;

    wire logic doWrite = awHeld_q & wHeld_q & ~bValid_q;
    wire logic [7:0] wrOff = awAddr_q - ADDR_PROF_BASE;
    wire logic [1:0] wrIdx = wrOff[4:3];
    wire logic wrIsPoff = wrOff[2];
    wire logic wrCtrl = awAddr_q == ADDR_CTRL;
    wire logic wrSweep = awAddr_q == ADDR_SWEEP;
    wire logic wrProf = (awAddr_q >= ADDR_PROF_BASE) &&
                        (awAddr_q <= ADDR_PROF_LAST) &&
                        (awAddr_q[1:0] == 2'h0);
    wire logic wrOk = wrCtrl || wrSweep || wrProf;

    wire logic [31:0] byteMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                                  {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wire logic [31:0] wrOld = wrCtrl ? ctrlBuf_q : wrSweep ? sweepBuf_q :
        wrIsPoff ? 32'(profBuf_q[wrIdx].poff) : profBuf_q[wrIdx].freq_tuning_word;
    wire logic [31:0] wrNew = (wrOld & ~byteMask) | (wData_q & byteMask);

    wire logic [7:0] rdOff = araddr - ADDR_PROF_BASE;
    wire logic [1:0] rdIdx = rdOff[4:3];
    wire logic rdAligned = araddr[1:0] == 2'h0;
    wire logic rdProf = (araddr >= ADDR_PROF_BASE) &&
                        (araddr <= ADDR_PROF_LAST);
    wire logic [31:0] statusWord = {24'h000000, 2'(pumpMode), profileSelect,
                                    cfg.sleep, cfg.sweep, 1'b0, cfg.refHalf};
    logic [31:0] rdMux;
    logic rdOk;

    always_comb begin
        rdOk = rdAligned;
        if (araddr == ADDR_CTRL) begin
            rdMux = ctrlBuf_q;
        end else if (araddr == ADDR_SWEEP) begin
            rdMux = sweepBuf_q;
        end else if (araddr == ADDR_STATUS) begin
            rdMux = statusWord;
        end else if (araddr == ADDR_PHASE) begin
            rdMux = acc_q;
        end else if (rdProf && rdOff[2]) begin
            rdMux = 32'(profBuf_q[rdIdx].poff);
        end else if (rdProf) begin
            rdMux = profBuf_q[rdIdx].freq_tuning_word;
        end else begin
            rdMux = 32'h0000_0000;
            rdOk = 1'b0;
        end
        if (!rdAligned) begin
            rdMux = 32'h0000_0000;
        end
    end

    // bus slave: address and data taken in either order, one write at a time
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
        end else if (clkEn) begin
            if (awvalid && awReady_q) begin
                awReady_q <= 1'b0;
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wReady_q) begin
                wReady_q <= 1'b0;
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite) begin
                bValid_q <= 1'b1;
                bResp_q <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end
            if (bValid_q && bready) begin
                bValid_q <= 1'b0;
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                awReady_q <= 1'b1;
                wReady_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            arReady_q <= 1'b1;
            rValid_q <= 1'b0;
            rData_q <= 32'h0000_0000;
            rResp_q <= RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arReady_q) begin
                arReady_q <= 1'b0;
                rValid_q <= 1'b1;
                rData_q <= rdMux;
                rResp_q <= rdOk ? RESP_OKAY : RESP_SLVERR;
            end else if (rValid_q && rready) begin
                rValid_q <= 1'b0;
                arReady_q <= 1'b1;
            end
        end
    end

    // software writes land in the buffers; the strobe edge makes them live
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlBuf_q <= CTRL_RESET;
            sweepBuf_q <= SWEEP_RESET;
            ctrlAct_q <= CTRL_RESET;
            sweepAct_q <= SWEEP_RESET;
            updPrev_q <= 1'b0;
            profBuf_q <= '{default: '0};
            profAct_q <= '{default: '0};
        end else if (clkEn) begin
            updPrev_q <= updateStrobe;
            if (doWrite && wrOk && wrCtrl) begin
                ctrlBuf_q <= wrNew;
            end
            if (doWrite && wrOk && wrSweep) begin
                sweepBuf_q <= wrNew;
            end
            if (doWrite && wrOk && wrProf && !wrIsPoff) begin
                profBuf_q[wrIdx].freq_tuning_word <= wrNew;
            end
            if (doWrite && wrOk && wrProf && wrIsPoff) begin
                profBuf_q[wrIdx].poff <= wrNew[13:0];
            end
            if (updRise) begin
                ctrlAct_q <= ctrlBuf_q;
                sweepAct_q <= sweepBuf_q;
                profAct_q <= profBuf_q;
            end
        end
    end

    // mclk stands in for the reference clock; the system clock is a tick
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncCnt_q <= '0;
            syncClk_q <= 1'b0;
            halfPhase_q <= 1'b0;
            sysTick_q <= 1'b0;
        end else if (clkEn) begin
            syncCnt_q <= syncCnt_q + SYNC_CNT_W'(1);
            syncClk_q <= syncCnt_q[SYNC_CNT_W-1];
            halfPhase_q <= ~halfPhase_q;
            sysTick_q <= ~cfg.sleep & (~cfg.refHalf | halfPhase_q);
        end
    end

    // phase continuous: a new word never clears the accumulator
    wire logic [31:0] activeFtw = cfg.sweep ? sweepFtw_q : selProf.freq_tuning_word;
    wire logic [31:0] accNext = acc_q + activeFtw;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= 32'h0000_0000;
            sweepFtw_q <= 32'h0000_0000;
            phase_q <= 14'h0000;
        end else if (clkEn) begin
            if (updRise) begin
                sweepFtw_q <= profBuf_q[profileSelect].freq_tuning_word;
            end else if (sysTick_q && cfg.sweep) begin
                sweepFtw_q <= sweepFtw_q + sweepAct_q;
            end
            if (sysTick_q) begin
                acc_q <= accNext;
            end
            if (cfg.sleep) begin
                phase_q <= 14'h0000;
            end else begin
                phase_q <= acc_q[31:18] + selProf.poff;
            end
        end
    end

    wire logic refEdge;
    wire logic fbEdge;

    dnpc_pfd_div u_ref_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .sigIn(pfdReferenceInput),
        .ratio(cfg.refDiv),
        .edgeOut(refEdge)
    );

    dnpc_pfd_div u_fb_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .sigIn(pfdFeedbackInput),
        .ratio(cfg.fbDiv),
        .edgeOut(fbEdge)
    );

    // a fresh update restarts the lock sequence from frequency detect
    dnpc_cp_ctrl u_cp (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .restart(updRise | cfg.sleep),
        .refEdge(refEdge),
        .fbEdge(fbEdge),
        .freqLock(freqLockDet),
        .phaseLock(phaseLockDet),
        .cfg(cfg),
        .pumpUp(pumpUp),
        .pumpDown(pumpDown),
        .pumpMode(pumpMode),
        .pumpScale(pumpScale),
        .fastLockActive(fastLockActive)
    );

    assign awready = awReady_q;
    assign wready = wReady_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign arready = arReady_q;
    assign rvalid = rValid_q;
    assign rdata = rData_q;
    assign rresp = rResp_q;
    assign syncClockOut = syncClk_q;
    assign systemClockTick = sysTick_q;
    assign phaseOut = phase_q;
endmodule

// [verification/dnpc_top_props.sv]
`timescale 1ns/1ns
module dnpc_top_props import dnpc_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic updateStrobe,
    input wire logic syncClockOut,
    input wire logic pumpUp,
    input wire logic pumpDown,
    input wire dnpc_cpmode_t pumpMode,
    input wire logic [5:0] pumpScale,
    input wire logic fastLockActive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sync_period_a: assert property (
        $rose(syncClockOut) |=> syncClockOut[*3] ##1 !syncClockOut[*4]
        ##1 syncClockOut) else $error("sync clock period wrong");
    sync_hold_a: assert property (
        $changed(syncClockOut) |=> $stable(syncClockOut)[*3])
        else $error("sync clock changed early");
    strobe_restart_a: assert property (
        $rose(updateStrobe) |-> ##2 (pumpMode == CP_FDET && !pumpUp
        && !pumpDown)) else $error("pump not restarted by update");
    final_scale_a: assert property (
        pumpMode == CP_FINAL |-> pumpScale inside {[6'h01:6'h08]})
        else $error("final scale out of range");
    wide_scale_a: assert property (
        pumpMode == CP_WIDE |-> !pumpScale[0] && pumpScale <= 6'h0e)
        else $error("wide scale out of range");
    fdet_scale_a: assert property (
        pumpMode == CP_FDET |->
        pumpScale inside {6'h00, 6'h14, 6'h28, 6'h3c})
        else $error("detect scale out of range");
    wide_entry_a: assert property (
        pumpMode == CP_WIDE && $past(pumpMode) != CP_WIDE |->
        $past(pumpMode) == CP_FDET) else $error("wide entered wrongly");
    fast_flag_a: assert property (
        fastLockActive |-> pumpMode == CP_FDET)
        else $error("fast lock flag outside detect");
endmodule
bind dnpc_top dnpc_top_props u_dnpc_top_props (.mclk(mclk),
    .reset_n(reset_n), .updateStrobe(updateStrobe),
    .syncClockOut(syncClockOut), .pumpUp(pumpUp), .pumpDown(pumpDown),
    .pumpMode(pumpMode), .pumpScale(pumpScale),
    .fastLockActive(fastLockActive));

// [verification/dnpc_host_model.sv]
`timescale 1ns/1ns
// host side pins: profile and update move only on a sync clock rise
module dnpc_host_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic syncClockOut,
    input wire logic [1:0] reqProfile,
    input wire logic reqStrobe,
    output logic [1:0] profileSelect,
    output logic updateStrobe
);
    logic syncPrev_q;
    wire syncRise = syncClockOut && !syncPrev_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncPrev_q <= 1'b0;
            profileSelect <= 2'h0;
            updateStrobe <= 1'b0;
        end else begin
            syncPrev_q <= syncClockOut;
            if (syncRise) begin
                profileSelect <= reqProfile;
                updateStrobe <= reqStrobe;
            end
        end
    end
endmodule

// [verification/dnpc_top_bench.sv]
`timescale 1ns/1ns
module dnpc_top_bench import dnpc_pkg::*; ();
    logic mclk = 1'b0, reset_n = 1'b0, clkEn = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, reqStrobe = 1'b0;
    logic pfdRef = 1'b0, pfdFb = 1'b0, freqLock = 1'b0, phaseLock = 1'b0;
    logic [1:0] reqProfile = 2'h0, profileSelect, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, updateStrobe;
    logic syncClockOut, systemClockTick, pumpUp, pumpDown, fastLockActive;
    logic [13:0] phaseOut;
    logic [5:0] pumpScale;
    dnpc_cpmode_t pumpMode;
    int miscompares = 0, total_checks = 0;
    dnpc_top u_dnpc_top (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .profileSelect(profileSelect),
        .updateStrobe(updateStrobe), .pfdReferenceInput(pfdRef),
        .pfdFeedbackInput(pfdFb), .freqLockDet(freqLock),
        .phaseLockDet(phaseLock), .syncClockOut(syncClockOut),
        .systemClockTick(systemClockTick), .phaseOut(phaseOut),
        .pumpUp(pumpUp), .pumpDown(pumpDown), .pumpMode(pumpMode),
        .pumpScale(pumpScale), .fastLockActive(fastLockActive));
    dnpc_host_model u_dnpc_host_model (.mclk(mclk), .reset_n(reset_n),
        .syncClockOut(syncClockOut), .reqProfile(reqProfile),
        .reqStrobe(reqStrobe), .profileSelect(profileSelect),
        .updateStrobe(updateStrobe));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = RESP_OKAY);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 60);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        if (n >= 60) miscompares++;
        tick(1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 60);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
        if (n >= 60) miscompares++;
        tick(1);
    endtask
    task automatic update;
        int n = 0;
        reqStrobe <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (updateStrobe !== 1'b1 && n < 40);
        reqStrobe <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (updateStrobe !== 1'b0 && n < 80);
        if (n >= 80) miscompares++;
        tick(4);
    endtask
    task automatic sel(input logic [1:0] p);
        reqProfile <= p;
        tick(20);
    endtask
    task automatic meas(input int k, input logic [13:0] e);
        logic [13:0] p0;
        p0 = phaseOut;
        tick(k);
        chk(32'(14'(phaseOut - p0)), 32'(e));
    endtask
    function automatic logic [31:0] cw(input int fd, wd, fn, off, pol);
        return 32'((fd << CTRL_FDET_LO) | (wd << CTRL_WIDE_LO)
            | (fn << CTRL_FINAL_LO) | (off << CTRL_CP_OFFSET)
            | (pol << CTRL_CP_POL));
    endfunction
    task automatic t_regs;
        chk(32'(pumpMode), 32'(CP_FDET));
        chk(32'(pumpScale), 32'h0);
        rdchk(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
        rdchk(ADDR_SWEEP, SWEEP_RESET, RESP_OKAY);
        rdchk(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h31, 32'h1, RESP_SLVERR);
        wr(8'h1c, 32'hffff_ffff);
        rdchk(8'h1c, 32'h0000_3fff, RESP_OKAY);
        wr(8'h28, 32'h89ab_cdef);
        rdchk(8'h28, 32'h89ab_cdef, RESP_OKAY);
    endtask
    task automatic t_nco;
        logic [13:0] q;
        wr(8'h10, 32'h0004_0000);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h0008_0000);
        wr(8'h1c, 32'h100);
        wr(8'h20, 32'hfffc_0000);
        wr(8'h24, 32'h0);
        wr(8'h28, 32'h0);
        wr(8'h2c, 32'h1234);
        wr(ADDR_CTRL, 32'h0);
        update;
        sel(2'h0);
        meas(20, 14'h14);
        sel(2'h1);
        meas(20, 14'h28);
        sel(2'h2);
        meas(20, 14'h3fec);
        wr(ADDR_CTRL, 32'h1 << CTRL_REF_HALF);
        update;
        sel(2'h0);
        meas(20, 14'h0a);
        wr(ADDR_CTRL, 32'h0);
        update;
        sel(2'h3);
        q = phaseOut;
        wr(8'h2c, 32'h0234);
        chk(32'(phaseOut), 32'(q));
        update;
        chk(32'(14'(phaseOut - q)), 32'h3000);
    endtask
    task automatic t_sleep;
        wr(ADDR_CTRL, 32'h1 << CTRL_SLEEP);
        chk(32'(systemClockTick), 32'h1);
        update;
        chk(32'(phaseOut), 32'h0);
        chk(32'(systemClockTick), 32'h0);
        wr(ADDR_CTRL, 32'h0);
        update;
    endtask
    task automatic t_sweep;
        logic [13:0] a, b, c;
        sel(2'h0);
        wr(ADDR_SWEEP, 32'h0004_0000);
        wr(ADDR_CTRL, 32'h1 << CTRL_SWEEP);
        update;
        a = phaseOut;
        tick(1);
        b = phaseOut;
        tick(1);
        c = phaseOut;
        chk(32'(14'(c - b - (b - a))), 32'h1);
        wr(ADDR_CTRL, 32'h0);
        update;
    endtask
    task automatic t_pump;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL, cw(i % 4, i, i % 4, i / 4, 0));
            update;
            chk(32'(pumpMode), 32'(CP_FDET));
            chk(32'(pumpScale), 32'(20 * (i % 4)));
            chk(32'(fastLockActive), 32'h1);
            freqLock <= 1'b1;
            tick(6);
            chk(32'(pumpMode), 32'(i == 0 ? CP_FINAL : CP_WIDE));
            if (i != 0) chk(32'(pumpScale), 32'(2 * i));
            phaseLock <= 1'b1;
            tick(6);
            chk(32'(pumpMode), 32'(CP_FINAL));
            chk(32'(pumpScale), 32'(i % 4 + 1 + 4 * (i / 4)));
            freqLock <= 1'b0;
            phaseLock <= 1'b0;
        end
    endtask
    task automatic t_pol;
        logic up, dn;
        for (int p = 0; p < 2; p++) begin
            for (int o = 0; o < 2; o++) begin
                wr(ADDR_CTRL, cw(0, 0, 0, 0, p));
                update;
                up = 1'b0;
                dn = 1'b0;
                if (o == 0) pfdRef <= 1'b1;
                else pfdFb <= 1'b1;
                repeat (4) begin
                    @(posedge mclk);
                    up |= pumpUp;
                    dn |= pumpDown;
                end
                pfdRef <= 1'b0;
                pfdFb <= 1'b0;
                chk(32'(up), 32'(o == p));
                chk(32'(dn), 32'(o != p));
            end
        end
    endtask
    task automatic t_div;
        wr(ADDR_CTRL, 32'(DIV_BY2) << CTRL_REF_DIV_LO);
        update;
        repeat (2) begin
            chk(32'(pumpUp), 32'h0);
            pfdRef <= 1'b1;
            tick(1);
            pfdRef <= 1'b0;
            tick(2);
        end
        chk(32'(pumpUp), 32'h1);
    endtask
    initial begin
        tick(6);
        reset_n <= 1'b1;
        tick(2);
        t_regs;
        t_nco;
        t_sleep;
        t_sweep;
        t_pump;
        t_pol;
        t_div;
        test_done;
    end
    initial begin
        #300000;
        miscompares++;
        test_done;
    end
endmodule
